//--- srs_params.svh
// constants for the status reporting block
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH
`define SRS_W 8
`define SRS_GW 16
`define SRS_ZERO8 8'h00
`define SRS_ZERO16 16'h0000
`define SRS_SRE_KEEP 8'hbf
`define SRS_ESR_KEEP 8'hfd
`define SRS_STB_ERRQ 2
`define SRS_STB_QUES 3
`define SRS_STB_MAV 4
`define SRS_STB_ESB 5
`define SRS_STB_RQS 6
`define SRS_STB_OPER 7
`define SRS_EV_OPC 0
`define SRS_EV_QYE 2
`define SRS_EV_DDE 3
`define SRS_EV_EXE 4
`define SRS_EV_CME 5
`define SRS_EV_URQ 6
`define SRS_EV_PON 7
`define SRS_CLS_ALL 1'b1
`endif

//--- srs_pkg.sv
// types shared by the status reporting block
package srs_pkg;
	typedef logic [7:0] srs_byte_t;
	typedef logic [15:0] srs_group_t;
	typedef enum logic [1:0] {
		SRS_SEL_SRE,
		SRS_SEL_ESE,
		SRS_SEL_ESR,
		SRS_SEL_STB
	} srs_sel_t;
endpackage

//--- srs_group.sv
// one generic status group: condition, transition filters, event, enable, summary
`timescale 1ns/1ps
`include "srs_params.svh"
module srs_group (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// condition inputs, already synchronous
	input wire srs_pkg::srs_group_t cond,
	// filters and enable
	input wire srs_pkg::srs_group_t ntr,
	input wire srs_pkg::srs_group_t ptr,
	input wire srs_pkg::srs_group_t ena,
	// clears
	input wire logic read_clr,
	input wire logic cls,
	// results
	output srs_pkg::srs_group_t cond_q,
	output srs_pkg::srs_group_t event_q,
	output logic summary_q
);
	import srs_pkg::*;
	srs_group_t cond_d;
	srs_group_t event_d;
	logic summary_d;
	// every bit handled alike
	genvar i;
	generate
		for (i = 0; i < `SRS_GW; i++) begin : g_bit
			logic rise;
			logic fall;
			assign rise = cond[i] & ~cond_q[i] & ptr[i];
			assign fall = ~cond[i] & cond_q[i] & ntr[i];
			// set wins over a clearing read in the same cycle
			assign event_d[i] = rise | fall | (event_q[i] & ~read_clr & ~cls);
		end
	endgenerate
	always_comb begin
		cond_d = cond;
		summary_d = |(event_d & ena);
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			cond_q <= `SRS_ZERO16;
			event_q <= `SRS_ZERO16;
			summary_q <= 1'b0;
		end else begin
			cond_q <= cond_d;
			event_q <= event_d;
			summary_q <= summary_d;
		end
	end
endmodule

//--- srs_status.sv
// status byte, service request mask and standard event group
//
// How it works
// - status byte bit reaches request summary only when its mask bit is set
// - mask bit 6 never stored, so the summary cannot enable itself
// - mask written as byte value and read back as stored
// - condition registers follow their live inputs every cycle
// - enabled falling condition bit sets its event bit
// - enabled rising condition bit sets its event bit
// - event bits stick until read or clear-status command
// - group summary is OR of event bits ANDed with enable bits
// - standard event bits are set directly by event pulses, no filters
// - standard event summary drives status byte bit 5
// - bit 0 set when pending operations complete after operation-complete request
// - bit 1 always reads zero
// - bit 2 set on query error
// - bit 3 set on device dependent error
// - bit 4 set on execution error
// - bit 5 set on command error
// - bit 6 set on local user request, even in lockout
// - bit 7 set after power cycle
// - standard event read returns all set bits
// - standard event mask written as byte value
// - standard event mask reads back last written value
// - status byte bit 6 is masked OR of status byte, shown in read value
// - bits 7,3,2,4 carry operation, questionable, error queue, message flags
`timescale 1ns/1ps
`include "srs_params.svh"
module srs_status (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// command port from the controller parser
	input wire logic wr_en,
	input wire logic rd_en,
	input wire srs_pkg::srs_sel_t sel,
	input wire srs_pkg::srs_byte_t wr_data,
	input wire logic cls,
	input wire logic opc_arm,
	output srs_pkg::srs_byte_t rd_data_q,
	output logic rd_valid_q,
	// firmware event pulses
	input wire logic ops_done,
	input wire logic query_err,
	input wire logic device_err,
	input wire logic exec_err,
	input wire logic cmd_err,
	input wire logic user_request,
	input wire logic power_on,
	// status byte sources
	input wire logic err_queue_nonempty,
	input wire logic msg_available,
	// operation group
	input wire srs_pkg::srs_group_t oper_cond,
	input wire srs_pkg::srs_group_t oper_ntr,
	input wire srs_pkg::srs_group_t oper_ptr,
	input wire srs_pkg::srs_group_t oper_ena,
	input wire logic oper_read,
	output srs_pkg::srs_group_t oper_event_q,
	// questionable group
	input wire srs_pkg::srs_group_t ques_cond,
	input wire srs_pkg::srs_group_t ques_ntr,
	input wire srs_pkg::srs_group_t ques_ptr,
	input wire srs_pkg::srs_group_t ques_ena,
	input wire logic ques_read,
	output srs_pkg::srs_group_t ques_event_q,
	// summaries
	output srs_pkg::srs_byte_t status_byte_q,
	output logic master_request_summary_q
);
	import srs_pkg::*;
	// ****************************************
	// registers and their next values
	// ****************************************
	srs_byte_t service_request_mask_q;
	srs_byte_t service_request_mask_d;
	srs_byte_t standard_event_mask_q;
	srs_byte_t standard_event_mask_d;
	srs_byte_t standard_event_flags_q;
	srs_byte_t standard_event_flags_d;
	logic opc_pend_q;
	logic opc_pend_d;
	srs_byte_t status_byte_d;
	logic msr_d;
	srs_byte_t rd_data_d;
	logic rd_valid_d;
	// ****************************************
	// decoded commands and status sources
	// ****************************************
	// flag bit 1 is never kept: the device never asks for control
	localparam srs_byte_t esr_keep = `SRS_ESR_KEEP;
	logic sre_write;
	logic ese_write;
	logic esr_read;
	logic esr_clear;
	srs_byte_t esr_set;
	srs_byte_t stb_src;
	srs_byte_t stb_masked;
	logic oper_sum_q;
	logic ques_sum_q;
	genvar b;
	genvar m;
	// ****************************************
	// operation and questionable groups
	// ****************************************
	// condition copies stay inside the groups; only events and summaries leave
	srs_group u_oper (
		.clk(clk),
		.srst(srst),
		.cond(oper_cond),
		.ntr(oper_ntr),
		.ptr(oper_ptr),
		.ena(oper_ena),
		.read_clr(oper_read),
		.cls(cls),
		.cond_q(),
		.event_q(oper_event_q),
		.summary_q(oper_sum_q)
	);
	srs_group u_ques (
		.clk(clk),
		.srst(srst),
		.cond(ques_cond),
		.ntr(ques_ntr),
		.ptr(ques_ptr),
		.ena(ques_ena),
		.read_clr(ques_read),
		.cls(cls),
		.cond_q(),
		.event_q(ques_event_q),
		.summary_q(ques_sum_q)
	);
	// ****************************************
	// command decode
	// ****************************************
	// back to back commands are fine; a read in a write cycle sees the old mask
	always_comb begin
		sre_write = 1'b0;
		ese_write = 1'b0;
		esr_read = 1'b0;
		// writes aimed at the flag register or the status byte are dropped
		if (wr_en) begin
			unique case (sel)
				SRS_SEL_SRE: begin
					sre_write = 1'b1;
				end
				SRS_SEL_ESE: begin
					ese_write = 1'b1;
				end
				SRS_SEL_ESR, SRS_SEL_STB: begin
				end
			endcase
		end
		if (rd_en) begin
			esr_read = (sel == SRS_SEL_ESR);
		end
		// a flag query and the clear command both empty the flag register
		esr_clear = esr_read | cls;
	end
	// ****************************************
	// operation complete tracking
	// ****************************************
	// a completion only counts while a request for it is pending
	always_comb begin
		opc_pend_d = opc_pend_q;
		// a fresh arm wins over a completion in the same cycle
		if (opc_arm) begin
			opc_pend_d = 1'b1;
		end else if (ops_done) begin
			opc_pend_d = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			opc_pend_q <= 1'b0;
		end else begin
			opc_pend_q <= opc_pend_d;
		end
	end
	// ****************************************
	// standard event group
	// ****************************************
	// events arrive as one-cycle pulses; no condition copy, no filters
	always_comb begin
		esr_set = `SRS_ZERO8;
		esr_set[`SRS_EV_OPC] = opc_pend_q & ops_done;
		esr_set[`SRS_EV_QYE] = query_err;
		esr_set[`SRS_EV_DDE] = device_err;
		esr_set[`SRS_EV_EXE] = exec_err;
		esr_set[`SRS_EV_CME] = cmd_err;
		esr_set[`SRS_EV_URQ] = user_request;
		esr_set[`SRS_EV_PON] = power_on;
	end
	// set wins over the clearing read, so no event slips between read and clear
	generate
		for (b = 0; b < `SRS_W; b++) begin : g_flag
			assign standard_event_flags_d[b] = esr_keep[b]
				& (esr_set[b] | (standard_event_flags_q[b] & ~esr_clear));
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (srst) begin
			standard_event_flags_q <= `SRS_ZERO8;
		end else begin
			standard_event_flags_q <= standard_event_flags_d;
		end
	end
	// ****************************************
	// request mask
	// ****************************************
	// a write lands at its edge; a read one cycle later sees it
	always_comb begin
		service_request_mask_d = service_request_mask_q;
		if (sre_write) begin
			// bit 6 is the summary itself, so it is never stored
			service_request_mask_d = wr_data & `SRS_SRE_KEEP;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			service_request_mask_q <= `SRS_ZERO8;
		end else begin
			service_request_mask_q <= service_request_mask_d;
		end
	end
	// ****************************************
	// event mask
	// ****************************************
	// every event flag may be enabled, unlike the request mask
	always_comb begin
		standard_event_mask_d = standard_event_mask_q;
		if (ese_write) begin
			standard_event_mask_d = wr_data;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			standard_event_mask_q <= `SRS_ZERO8;
		end else begin
			standard_event_mask_q <= standard_event_mask_d;
		end
	end
	// ****************************************
	// status byte and request summary
	// ****************************************
	// group summaries arrive registered from next events, so they change in the same cycle as their events
	always_comb begin
		stb_src = `SRS_ZERO8;
		stb_src[`SRS_STB_ERRQ] = err_queue_nonempty;
		stb_src[`SRS_STB_QUES] = ques_sum_q;
		stb_src[`SRS_STB_MAV] = msg_available;
		stb_src[`SRS_STB_OPER] = oper_sum_q;
		// next flags, so the summary lines up with the flag register
		stb_src[`SRS_STB_ESB] = |(standard_event_flags_d & standard_event_mask_q);
	end
	// each source bit passes only under its own mask bit
	generate
		for (m = 0; m < `SRS_W; m++) begin : g_request
			assign stb_masked[m] = stb_src[m] & service_request_mask_q[m];
		end
	endgenerate
	always_comb begin
		// mask bit 6 is always clear, so the summary never feeds itself
		msr_d = |stb_masked;
		status_byte_d = stb_src;
		status_byte_d[`SRS_STB_RQS] = msr_d;
	end
	// the master summary is a registered copy of status byte bit 6
	always_ff @(posedge clk) begin
		if (srst) begin
			status_byte_q <= `SRS_ZERO8;
			master_request_summary_q <= 1'b0;
		end else begin
			status_byte_q <= status_byte_d;
			master_request_summary_q <= msr_d;
		end
	end
	// ****************************************
	// query answers
	// ****************************************
	always_comb begin
		rd_valid_d = rd_en;
		rd_data_d = `SRS_ZERO8;
		if (rd_en) begin
			unique case (sel)
				SRS_SEL_SRE: rd_data_d = service_request_mask_q;
				SRS_SEL_ESE: rd_data_d = standard_event_mask_q;
				SRS_SEL_ESR: rd_data_d = standard_event_flags_q;
				SRS_SEL_STB: rd_data_d = status_byte_q;
			endcase
		end
	end
	// an answer stands for one cycle, zero otherwise
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_data_q <= `SRS_ZERO8;
			rd_valid_q <= 1'b0;
		end else begin
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end
endmodule

//--- srs_status_chk.sv
// assertion checker for the status reporting block
`timescale 1ns/1ps
module srs_status_chk (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// command port
	input wire logic wr_en,
	input wire logic rd_en,
	input wire srs_pkg::srs_sel_t sel,
	input wire srs_pkg::srs_byte_t wr_data,
	input wire logic cls,
	input wire logic cmd_err,
	input wire srs_pkg::srs_byte_t rd_data_q,
	// operation group
	input wire srs_pkg::srs_group_t oper_cond,
	input wire srs_pkg::srs_group_t oper_ptr,
	input wire srs_pkg::srs_group_t oper_ntr,
	input wire logic oper_read,
	input wire srs_pkg::srs_group_t oper_event_q
);
	import srs_pkg::*;
	srs_byte_t sre_m, ese_m;
	srs_group_t oc_q, rise, fall;
	logic rd_sre, rd_ese, rd_esr;
	// shadow masks, so read-back is judged against the writes
	always_ff @(posedge clk) begin
		oc_q <= srst ? 16'h0000 : oper_cond;
		sre_m <= srst ? 8'h00 : (wr_en && sel == SRS_SEL_SRE) ? wr_data & 8'hbf : sre_m;
		ese_m <= srst ? 8'h00 : (wr_en && sel == SRS_SEL_ESE) ? wr_data : ese_m;
	end
	assign rise = oper_cond & ~oc_q & oper_ptr;
	assign fall = ~oper_cond & oc_q & oper_ntr;
	assign rd_sre = rd_en && sel == SRS_SEL_SRE;
	assign rd_ese = rd_en && sel == SRS_SEL_ESE;
	assign rd_esr = rd_en && sel == SRS_SEL_ESR;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	chk_sre_readback: assert property (rd_sre |=> rd_data_q == $past(sre_m))
		else $error("request mask read-back wrong");
	chk_ese_readback: assert property (rd_ese |=> rd_data_q == $past(ese_m))
		else $error("event mask read-back wrong");
	chk_sre_no_bit6: assert property (rd_sre |=> !rd_data_q[6])
		else $error("request mask bit 6 stored");
	chk_esr_bit1_zero: assert property (rd_esr |=> !rd_data_q[1])
		else $error("event flag bit 1 set");
	chk_cmd_err_flag: assert property (cmd_err ##1 rd_esr |=> rd_data_q[5])
		else $error("command error not flagged");
	chk_rise_latch: assert property (rise != 0 |=> (oper_event_q & $past(rise)) == $past(rise))
		else $error("rising edge not latched");
	chk_fall_latch: assert property (fall != 0 |=> (oper_event_q & $past(fall)) == $past(fall))
		else $error("falling edge not latched");
	chk_event_sticky: assert property (!$past(oper_read) && !$past(cls)
		|-> (oper_event_q & $past(oper_event_q)) == $past(oper_event_q)) else $error("event lost");
endmodule
bind srs_status srs_status_chk chk_u (.*);

//--- srs_ctl_model.sv
// remote controller model issuing the status commands
`timescale 1ns/1ps
module srs_ctl_model (
	// clock
	input wire logic clk,
	// command port
	output logic wr_en,
	output logic rd_en,
	output srs_pkg::srs_sel_t sel,
	output srs_pkg::srs_byte_t wr_data,
	output logic cls,
	// answer
	input wire srs_pkg::srs_byte_t rd_data_q,
	input wire logic rd_valid_q
);
	import srs_pkg::*;
	initial begin
		{wr_en, rd_en, cls} = 3'h0;
		sel = SRS_SEL_STB;
		wr_data = 8'h5a;
	end
	// a mask goes out as one byte, the sum of enabled weights
	task automatic put(input srs_sel_t s, input srs_byte_t v);
		@(negedge clk);
		sel = s;
		wr_data = v;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		wr_data = ~v;
	endtask
	// answer stands one cycle only; unknown if it never came
	task automatic ask(input srs_sel_t s, output srs_byte_t v);
		@(negedge clk);
		sel = s;
		rd_en = 1'b1;
		@(negedge clk);
		v = rd_valid_q ? rd_data_q : 8'hxx;
		rd_en = 1'b0;
	endtask
	task automatic clear();
		@(negedge clk);
		cls = 1'b1;
		@(negedge clk);
		cls = 1'b0;
	endtask
endmodule

//--- srs_status_tb_top.sv
// self-checking bench for the status reporting block
`timescale 1ns/1ps
module srs_status_tb_top;
	import srs_pkg::*;
	logic clk, srst, wr_en, rd_en, cls, opc_arm, rd_valid_q, oper_read, ques_read;
	logic ops_done, query_err, device_err, exec_err, cmd_err, user_request, power_on;
	logic err_queue_nonempty, msg_available, master_request_summary_q;
	srs_sel_t sel;
	srs_byte_t wr_data, rd_data_q, status_byte_q, ev, d, s, v;
	srs_byte_t sre_tab [4] = '{8'h20, 8'h00, 8'h40, 8'h34};
	srs_group_t oper_cond, oper_ntr, oper_ptr, oper_ena, oper_event_q, eo, po;
	srs_group_t ques_cond, ques_ntr, ques_ptr, ques_ena, ques_event_q, eqe, pq;
	int failures = 0;
	int check_count = 0;
	int seed = 35870;
	assign {power_on, user_request, cmd_err, exec_err, device_err, query_err} = ev[7:2];
	assign ops_done = ev[0];
	srs_status dut_u (.*);
	srs_ctl_model ctl_u (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic complete_run();
		if (failures == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic pulse(input int b);
		@(negedge clk);
		ev = 8'h01 << b;
		@(negedge clk);
		ev = 8'h00;
	endtask
	// query lands one cycle behind the event, so the event is in the answer
	task automatic fire(input int b, output srs_byte_t r);
		fork
			pulse(b);
			begin
				@(negedge clk);
				ctl_u.ask(SRS_SEL_ESR, r);
			end
		join
	endtask
	function automatic srs_byte_t stb_exp(logic o, q, e, m, esb, srs_byte_t sre);
		srs_byte_t x;
		x = {o, 1'b0, esb, m, q, e, 2'b00};
		x[6] = |(x & sre & 8'hbf);
		return x;
	endfunction
	initial begin
		#(25 * 4000);
		failures++;
		complete_run();
	end
	initial begin
		{srst, opc_arm, oper_read, ques_read, err_queue_nonempty, msg_available} = 6'h20;
		{oper_cond, oper_ntr, oper_ptr, oper_ena, eo, po} = 96'h0;
		{ques_cond, ques_ntr, ques_ptr, ques_ena, eqe, pq} = 96'h0;
		ev = 8'h00;
		repeat (12) @(negedge clk);
		srst = 1'b0;
		ctl_u.ask(SRS_SEL_SRE, d);
		chk("mask after reset", 16'h0000, d);
		for (int i = 0; i < 10; i++) begin
			v = (i == 0) ? 8'hff : 8'($random(seed));
			ctl_u.put(SRS_SEL_SRE, v);
			ctl_u.put(SRS_SEL_ESE, ~v);
			ctl_u.ask(SRS_SEL_SRE, d);
			chk("request mask", v & 8'hbf, d);
			ctl_u.ask(SRS_SEL_ESE, d);
			chk("event mask", {8'h00, ~v}, d);
		end
		fire(0, d);
		chk("unarmed completion", 16'h0000, d);
		@(negedge clk);
		opc_arm = 1'b1;
		@(negedge clk);
		opc_arm = 1'b0;
		for (int b = 0; b < 8; b++) begin
			fire(b, d);
			chk("event flag", (b == 1) ? 16'h0000 : 16'h0001 << b, d);
			ctl_u.ask(SRS_SEL_ESR, d);
			chk("flags after read", 16'h0000, d);
		end
		ctl_u.put(SRS_SEL_ESE, 8'h20);
		{err_queue_nonempty, msg_available} = 2'($random(seed));
		pulse(5);
		foreach (sre_tab[k]) begin
			ctl_u.put(SRS_SEL_SRE, sre_tab[k]);
			repeat (3) @(negedge clk);
			s = stb_exp(1'b0, 1'b0, err_queue_nonempty, msg_available, 1'b1, sre_tab[k]);
			chk("master summary", s[6], master_request_summary_q);
			chk("status byte out", s, status_byte_q);
			ctl_u.ask(SRS_SEL_STB, d);
			chk("status byte", s, d);
		end
		{oper_ptr, oper_ntr, oper_ena} = 48'({$random(seed), $random(seed)});
		{ques_ptr, ques_ntr, ques_ena} = 48'({$random(seed), $random(seed)});
		for (int i = 0; i < 24; i++) begin
			@(negedge clk);
			{oper_cond, ques_cond} = $random(seed);
			eo |= oper_cond & ~po & oper_ptr | ~oper_cond & po & oper_ntr;
			eqe |= ques_cond & ~pq & ques_ptr | ~ques_cond & pq & ques_ntr;
			po = oper_cond;
			pq = ques_cond;
		end
		repeat (3) @(negedge clk);
		chk("oper events", eo, oper_event_q);
		chk("ques events", eqe, ques_event_q);
		s = stb_exp(|(eo & oper_ena), |(eqe & ques_ena), err_queue_nonempty, msg_available, 1'b1, 8'h34);
		ctl_u.ask(SRS_SEL_STB, d);
		chk("group summaries", s, d);
		@(negedge clk);
		oper_read = 1'b1;
		@(negedge clk);
		oper_read = 1'b0;
		chk("oper after read", 16'h0000, oper_event_q);
		ctl_u.clear();
		chk("ques after clear", 16'h0000, ques_event_q);
		ctl_u.put(SRS_SEL_ESR, 8'hff);
		ctl_u.ask(SRS_SEL_ESR, d);
		chk("flags after clear", 16'h0000, d);
		complete_run();
	end
endmodule
